// ==== hw/rco_clock_select.sv ====
// recovered clock two control register, squelch and output clock generator
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ns

// Behaviour
// R01 - output drives only while enable bit 15 is set; resets to off.
// R02 - source field 14:11: 0000 port 0, 0001 port 1, other codes reserved.
// R03 - frequency field 10:8: 000 25 MHz, 001 125 MHz, 010 31.25 MHz.
// R04 - level 00 squelches on link down, unstable, unsupported modes or EEE.
// R05 - level 01 like 00 but passes 1000BASE-T master and 10BASE-T.
// R06 - level 01 keeps the clock in EEE while low-power idle is received.
// R07 - level 10 squelches only while the link is down.
// R08 - level 11 never squelches on link state.
// R09 - with squelch off and link down, the selected clock is still output.
// R10 - external squelch pin high forces the output low regardless of settings.
// R11 - type field 2:0: 000 serial media clock, 001 copper clock, resets 000.
// R12 - reserved bits 7:6 and 3 read zero and ignore writes.
module rco_clock_select (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input rco_pkg::rco_port_t port0_status,
	input rco_pkg::rco_port_t port1_status,
	input wire logic clk_squelch_in,
	output logic recovered_clock_two_output
);

	logic [15:0] ctrl_reg;
	logic [15:0] rdata_reg;
	logic [2:0] div_cnt_reg;
	logic div_clk_reg;
	logic out_reg;
	logic [3:0] status_reg;
	logic src_clk_prev_reg;

	logic enable;
	logic [3:0] src_sel;
	rco_pkg::rco_freq_t freq_sel;
	rco_pkg::rco_squelch_t sq_sel;
	logic [2:0] type_sel;
	rco_pkg::rco_port_t sel_port;
	logic cfg_valid;
	logic link_squelch;
	logic pass;
	logic [2:0] half_cnt;
	logic src_clk;

	// squelch decision for one port and one level
	function automatic logic squelch_for(input rco_pkg::rco_squelch_t lvl,
			input rco_pkg::rco_port_t p);
		logic unsup;
		logic eee_sq;
		logic down;
		unsup = (p.speed == rco_pkg::SPEED_10) ||
			((p.speed == rco_pkg::SPEED_1000) && p.master);
		eee_sq = p.eee_active && ((p.speed == rco_pkg::SPEED_100) ||
			((p.speed == rco_pkg::SPEED_1000) && !p.master));
		down = !p.link_up || !p.link_stable;
		unique case (lvl)
			rco_pkg::SQ_AUTO: squelch_for = down || unsup || eee_sq; // R04
			rco_pkg::SQ_AUTO_KEEP: squelch_for = down ||
				(eee_sq && !p.low_power_idle_symbol); // R05 R06
			rco_pkg::SQ_LINK_DOWN: squelch_for = !p.link_up; // R07
			rco_pkg::SQ_OFF: squelch_for = 1'b0; // R08 R09
		endcase
	endfunction

	assign enable = ctrl_reg[rco_pkg::EN_BIT];
	assign src_sel = ctrl_reg[rco_pkg::SRC_LSB +: 4];
	assign freq_sel = rco_pkg::rco_freq_t'(ctrl_reg[rco_pkg::FREQ_LSB +: 3]);
	assign sq_sel = rco_pkg::rco_squelch_t'(ctrl_reg[rco_pkg::SQ_LSB +: 2]);
	assign type_sel = ctrl_reg[rco_pkg::TYPE_LSB +: 3];

	always_comb begin
		sel_port = (src_sel == rco_pkg::SRC_PORT1) ? port1_status : port0_status; // R02
		src_clk = (type_sel == rco_pkg::TYPE_COPPER) ? sel_port.copper_clk
			: sel_port.serial_clk; // R11
		cfg_valid = ((src_sel == rco_pkg::SRC_PORT0) || (src_sel == rco_pkg::SRC_PORT1)) &&
			((type_sel == rco_pkg::TYPE_SERIAL) || (type_sel == rco_pkg::TYPE_COPPER)) &&
			((freq_sel == rco_pkg::FREQ_25) || (freq_sel == rco_pkg::FREQ_125) ||
			(freq_sel == rco_pkg::FREQ_31P25)); // R02 R03 R11
		link_squelch = squelch_for(sq_sel, sel_port);
		pass = enable && cfg_valid && !link_squelch && !clk_squelch_in; // R01 R10
		unique case (freq_sel)
			rco_pkg::FREQ_125: half_cnt = rco_pkg::HALF_125; // R03
			rco_pkg::FREQ_31P25: half_cnt = rco_pkg::HALF_31P25; // R03
			default: half_cnt = rco_pkg::HALF_25; // R03
		endcase
	end

	// control register; reserved bits masked so they stay zero
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ctrl_reg <= rco_pkg::CTRL_RESET; // R01 R11
		end else if (reg_wr && reg_addr == rco_pkg::ADDR_CTRL) begin
			ctrl_reg <= reg_wdata & rco_pkg::CTRL_WMASK; // R12
		end
	end

	// read data one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rdata_reg <= 16'h0000;
		end else if (reg_rd && reg_addr == rco_pkg::ADDR_CTRL) begin
			rdata_reg <= ctrl_reg; // R12
		end else if (reg_rd && reg_addr == rco_pkg::ADDR_STATUS) begin
			rdata_reg <= {12'h000, status_reg};
		end else begin
			rdata_reg <= 16'h0000;
		end
	end
	assign reg_rdata = rdata_reg;

	// status: pass, pin squelch, link squelch, config valid
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			status_reg <= 4'h0;
		end else begin
			status_reg <= {cfg_valid, link_squelch, clk_squelch_in, pass};
		end
	end

	// divider re-phased to the chosen recovered clock's rising edge;
	// held at zero while squelched so the output restarts with a full low phase; a squelch mid-high cuts the high phase short
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			src_clk_prev_reg <= 1'b0;
		end else begin
			src_clk_prev_reg <= src_clk;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst || !pass) begin
			div_cnt_reg <= 3'h0; // R01 R10
			div_clk_reg <= 1'b0;
		end else if (div_cnt_reg >= half_cnt - 3'h1) begin
			div_cnt_reg <= 3'h0; // R03
			div_clk_reg <= ~div_clk_reg;
		end else if (src_clk && !src_clk_prev_reg && !div_clk_reg && div_cnt_reg == 3'h0) begin
			div_cnt_reg <= 3'h0;
		end else begin
			div_cnt_reg <= div_cnt_reg + 3'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			out_reg <= 1'b0; // R01
		end else begin
			out_reg <= pass && !(div_cnt_reg >= half_cnt - 3'h1) ? div_clk_reg
				: (pass && ~div_clk_reg); // R04 R07 R10
		end
	end
	assign recovered_clock_two_output = out_reg;

endmodule

// ==== hw/rco_pkg.sv ====
// shared constants and types of the recovered clock two output select block
package rco_pkg;

	// register map, byte offsets on the register port
	localparam logic [4:0] ADDR_CTRL = 5'h18;
	localparam logic [4:0] ADDR_STATUS = 5'h1E;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] CTRL_WMASK = 16'hFF37;

	// control field positions
	localparam int EN_BIT = 15;
	localparam int SRC_LSB = 11;
	localparam int FREQ_LSB = 8;
	localparam int SQ_LSB = 4;
	localparam int TYPE_LSB = 0;

	localparam logic [3:0] SRC_PORT0 = 4'h0;
	localparam logic [3:0] SRC_PORT1 = 4'h1;
	localparam logic [2:0] TYPE_SERIAL = 3'h0;
	localparam logic [2:0] TYPE_COPPER = 3'h1;

	typedef enum logic [2:0] {
		FREQ_25 = 3'b000,
		FREQ_125 = 3'b001,
		FREQ_31P25 = 3'b010
	} rco_freq_t;

	typedef enum logic [1:0] {
		SQ_AUTO = 2'b00,
		SQ_AUTO_KEEP = 2'b01,
		SQ_LINK_DOWN = 2'b10,
		SQ_OFF = 2'b11
	} rco_squelch_t;

	typedef enum logic [1:0] {
		SPEED_10 = 2'b00,
		SPEED_100 = 2'b01,
		SPEED_1000 = 2'b10
	} rco_speed_t;

	// link state of one port, as seen by the clock select
	typedef struct packed {
		logic link_up;
		logic link_stable;
		rco_speed_t speed;
		logic master;
		logic eee_active;
		logic low_power_idle_symbol;
		logic serial_clk;
		logic copper_clk;
	} rco_port_t;

	// output clock timing, derived from the system clock rate
	localparam int SYS_KHZ = 250000;
	localparam int F25_KHZ = 25000;
	localparam int F125_KHZ = 125000;
	localparam int F31P25_KHZ = 31250;
	localparam logic [2:0] HALF_25 = 3'(SYS_KHZ / (2 * F25_KHZ));
	localparam logic [2:0] HALF_125 = 3'(SYS_KHZ / (2 * F125_KHZ));
	localparam logic [2:0] HALF_31P25 = 3'(SYS_KHZ / (2 * F31P25_KHZ));

endpackage

// ==== sim/rco_checker.sv ====
// port assertions for the clock select
`timescale 1ns/1ns
module rco_checker (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input rco_pkg::rco_port_t port0_status,
	input rco_pkg::rco_port_t port1_status,
	input wire logic clk_squelch_in,
	input wire logic recovered_clock_two_output
);
	logic [15:0] ctrl_reg;
	logic o;
	logic dn;
	assign o = recovered_clock_two_output;
	assign dn = !(ctrl_reg[11] ? port1_status.link_up : port0_status.link_up);
	// own copy of the control word, checks see only ports
	always_ff @(posedge clk_sys) begin
		if (srst)
			ctrl_reg <= 16'h0000;
		else if (reg_wr && reg_addr == rco_pkg::ADDR_CTRL)
			ctrl_reg <= reg_wdata & 16'hFF37;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	ctrl_read_a: assert property (reg_rd && reg_addr == rco_pkg::ADDR_CTRL
		|=> reg_rdata == $past(ctrl_reg)) else $error("bad read");
	unmapped_read_a: assert property (reg_rd && reg_addr == 5'h00
		|=> reg_rdata == 16'h0000) else $error("bad hole read");
	pin_squelch_a: assert property (clk_squelch_in [*5] |-> !o)
		else $error("pin ignored");
	output_off_a: assert property ((!ctrl_reg[15]) [*5] |-> !o)
		else $error("off but running");
	bad_source_a: assert property ((ctrl_reg[14:11] > 4'h1) [*5] |-> !o)
		else $error("bad source runs");
	bad_rate_a: assert property ((ctrl_reg[10:8] > 3'h2) [*5] |-> !o)
		else $error("bad rate runs");
	bad_type_a: assert property ((ctrl_reg[2:0] > 3'h1) [*5] |-> !o)
		else $error("bad type runs");
	link_down_a: assert property ((dn && ctrl_reg[5:4] != 2'h3) [*5] |-> !o)
		else $error("down not squelched");
	cover property (reg_rd && reg_addr == rco_pkg::ADDR_CTRL);
	cover property ($rose(o) && ctrl_reg[10:8] == 3'h1);
	cover property (clk_squelch_in && ctrl_reg[15]);
endmodule

// ==== sim/rco_clock_sink.sv ====
// timing device model: counts clock rises and high time
`timescale 1ns/1ns
module rco_clock_sink (
	input wire logic clk_sys,
	input wire logic clk_in,
	output logic [15:0] rise_cnt = 16'h0000,
	output logic [15:0] high_len = 16'h0000
);
	logic prev = 1'b0;
	logic [15:0] run = 16'h0000;
	// sampled on the system clock, so lengths are in cycles
	always @(posedge clk_sys) begin
		prev <= clk_in;
		run <= clk_in ? run + 16'h0001 : 16'h0000;
		if (clk_in && !prev)
			rise_cnt <= rise_cnt + 16'h0001;
		if (!clk_in && prev)
			high_len <= run;
	end
endmodule

// ==== sim/recovered_clock_output_select_tb_top.sv ====
// self-checking bench for the clock select
`timescale 1ns/1ns
module recovered_clock_output_select_tb_top;
	logic clk_sys = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, clk_squelch_in = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, rise_cnt, high_len;
	logic recovered_clock_two_output;
	rco_pkg::rco_port_t port0_status = 9'h000, port1_status = 9'h1C0;
	logic [2:0] half_len [3] = '{3'h5, 3'h1, 3'h4};
	int error_cnt = 0, num_checks = 0;
	rco_clock_select dut (.*);
	rco_clock_sink sink (.clk_in(recovered_clock_two_output), .*);
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	task complete_run;
		if (error_cnt == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t %h %h", $time, got, exp);
		end
	endtask
	task wr(input logic [15:0] d);
		reg_addr <= rco_pkg::ADDR_CTRL;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask
	task rd(input logic [4:0] a, input logic [15:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
		@(posedge clk_sys);
	endtask
	task row(input logic [15:0] c, input logic [8:0] a, input logic e);
		logic [15:0] n;
		port0_status <= a;
		wr(c);
		repeat (8) @(posedge clk_sys);
		#1 n = rise_cnt;
		repeat (20) @(posedge clk_sys);
		#1 chk(16'(rise_cnt != n), 16'(e));
		@(posedge clk_sys);
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		rd(rco_pkg::ADDR_CTRL, 16'h0000);
		wr(16'hFFFF);
		rd(rco_pkg::ADDR_CTRL, 16'hFF37);
		rd(5'h00, 16'h0000);
		for (int i = 0; i < 3; i++) begin
			wr(16'h8030 | 16'(i << 8));
			repeat (40) @(posedge clk_sys);
			#1 chk(high_len, 16'(half_len[i]));
		end
		row(16'h8100, 9'h1C0, 1'b1);
		row(16'h8100, 9'h1D0, 1'b0);
		row(16'h8110, 9'h1D0, 1'b1);
		row(16'h8100, 9'h1AC, 1'b0);
		row(16'h8110, 9'h1AC, 1'b1);
		row(16'h8120, 9'h140, 1'b1);
		row(16'h8120, 9'h000, 1'b0);
		row(16'h8920, 9'h000, 1'b1);
		row(16'h8131, 9'h000, 1'b1);
		clk_squelch_in <= 1'b1;
		row(16'h8131, 9'h000, 1'b0);
		rd(rco_pkg::ADDR_STATUS, 16'h000a);
		clk_squelch_in <= 1'b0;
		row(16'h0130, 9'h1C0, 1'b0);
		row(16'h9332, 9'h1C0, 1'b0);
		complete_run;
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		error_cnt++;
		complete_run;
	end
endmodule
bind rco_clock_select rco_checker chk_i (.*);
